// >>> bench/tfd_piezo.sv
// Piezo transducer model: counts drive pulses and high cycles.
// Assumes drive is the tone pin on clk; clr restarts the counts.
`timescale 1ns/1ps
module tfd_piezo
(
   input wire logic clk,
   input wire logic clr,
   input wire logic drive,
   output int rises,
   output int highs
);
   logic last;
   always_ff @(posedge clk)
   begin
      last <= clr ? 1'h0 : drive;
      rises <= clr ? 0 : rises + int'(drive & ~last);
      highs <= clr ? 0 : highs + int'(drive);
   end
endmodule : tfd_piezo

// >>> bench/tfd_tone_driver_bench.sv
// Bench of the tone driver: register tasks, shot timing, touch cases.
// Assumes scaled timing: 10 cycles a ms, tone base 40.
`timescale 1ns/1ps
module tfd_tone_driver_bench;
   localparam int MSC = 10;
   logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, pz_clr = 1;
   logic [13:0] touch_det = '0;
   logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata;
   logic tone_out, tone_active;
   int rises, highs, act, error_cnt = 0, num_checks = 0, cyc = 0;
   int fq[4] = '{1, 4, 8, 31};
   tfd_tone_driver #(.MS_CYCLES(MSC), .HALF_BASE(40)) dut (.clk(clk), .rst(rst), .touch_det(touch_det),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .tone_out(tone_out), .tone_active(tone_active));
   tfd_piezo pz (.clk(clk), .clr(pz_clr), .drive(tone_out), .rises(rises), .highs(highs));
   initial
   begin
      forever #20 clk = ~clk;
   end
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         test_done();
      end
   end
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got, input int tol = 0);
      num_checks++;
      if ($isunknown(got) || got + tol < exp || got > exp + tol)
      begin
         $display("[ERR] %s exp %0h got %0h", nm, exp, got);
         error_cnt++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      @(negedge clk);
      chk($sformatf("reg %0h", a), {8'h00, exp}, {8'h00, reg_rdata});
   endtask : rd
   task automatic touch(input logic [13:0] v);
      @(posedge clk);
      touch_det <= v;
   endtask : touch
   task automatic meas(input int lim);
      act = 0;
      for (int t = 0; t < lim; t++)
      begin
         @(negedge clk);
         if (tone_active === 1'h1)
            act++;
         else if (act > 0)
            break;
      end
      repeat (2) @(negedge clk);
   endtask : meas
   task automatic shot(input int lim);
      @(posedge clk);
      pz_clr <= 1'h1;
      @(posedge clk);
      pz_clr <= 1'h0;
      wr(8'h65, 8'h01);
      meas(lim);
   endtask : shot
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      rd(8'h62, 8'h00);
      rd(8'h63, 8'h00);
      rd(8'h64, 8'h00);
      wr(8'h63, 8'hFF);
      rd(8'h63, 8'h7F);
      wr(8'h64, 8'hC0);
      rd(8'h64, 8'h40);
      wr(8'h66, 8'h55);
      rd(8'h66, 8'h00);
      for (int d = 1; d < 7; d++)
      begin
         wr(8'h62, {d[2:0], 5'h00});
         rd(8'h62, {d[2:0], 5'h00});
         shot(3000);
         chk("dur", 16'(MSC << (d + 2)), 16'(act));
         chk("dc highs", 16'(MSC << (d + 2)), 16'(highs));
         chk("dc edges", 16'h0001, 16'(rises));
         chk("idle", 16'h0000, {15'h0000, tone_out});
         rd(8'h65, 8'h00);
      end
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h62, 8'h20 | 8'(fq[i]));
         shot(200);
         chk("edges", 16'(fq[i]), 16'(rises), 1);
         chk("highs", 16'h0028, 16'(highs), 2);
      end
      for (int i = 0; i < 2; i++)
      begin
         wr(8'h62, i ? 8'hE4 : 8'h04);
         shot(60);
         chk("ignored", 16'h0000, 16'(act));
      end
      touch(14'h0080);
      meas(60);
      chk("unlinked", 16'h0000, 16'(act));
      fork
         begin
            touch(14'h2000);
            repeat (50) @(posedge clk);
            touch(14'h0000);
         end
         meas(200);
      join
      chk("hold", 16'd51, 16'(act), 2);
      wr(8'h62, 8'h04);
      touch(14'h0001);
      meas(60);
      chk("dur off", 16'h0000, 16'(act));
      touch(14'h0000);
      wr(8'h62, 8'h20);
      touch(14'h0001);
      fork
         begin
            repeat (20) @(posedge clk);
            wr(8'h62, 8'h40);
         end
         meas(300);
      join
      chk("kept", 16'h0050, 16'(act));
      touch(14'h0000);
      shot(400);
      chk("applied", 16'h00A0, 16'(act));
      fork
         begin
            wr(8'h65, 8'h01);
            repeat (40) @(posedge clk);
            wr(8'h62, 8'h20);
            touch(14'h0001);
         end
         meas(400);
      join
      chk("restart", 16'h007C, 16'(act), 2);
      test_done();
   end
endmodule : tfd_tone_driver_bench

// >>> rtl/tfd_cfg.svh
// Constants of the touch feedback tone driver: offsets, fields, reset values, timing.
// Assumes a 25 MHz core clock and a register port fed by the serial host interface.
`ifndef TFD_CFG_SVH
`define TFD_CFG_SVH
`define TFD_ADDR_CONFIG 8'h62
`define TFD_ADDR_LINK_LO 8'h63
`define TFD_ADDR_LINK_HI 8'h64
`define TFD_ADDR_TRIGGER 8'h65
`define TFD_RESET_BYTE 8'h00
`define TFD_DUR_MSB 7
`define TFD_DUR_LSB 5
`define TFD_FREQ_MSB 4
`define TFD_FREQ_LSB 0
`define TFD_LINK_MSB 6
`define TFD_DUR_OFF 3'h0
`define TFD_DUR_HOLD 3'h7
`define TFD_FREQ_DC 5'h00
`define TFD_DUR_BASE_MS 9'h008
`define TFD_CLK_PERIOD_NS 40
`define TFD_CLK_HZ 25000000
`define TFD_MS_IN_NS 1000000
`define TFD_TONE_STEP_HZ 125
`endif

// >>> rtl/tfd_pkg.sv
// Types of the touch feedback tone driver.
// Assumes tfd_cfg.svh supplies the numeric constants.
package tfd_pkg;
   typedef enum logic [0:0] {TFD_IDLE = 1'b0, TFD_RUN = 1'b1} tfd_state_type;
endpackage : tfd_pkg

// >>> rtl/tfd_tone_driver.sv
// Touch feedback tone driver: configuration registers, trigger logic, duration timer.
// Assumes touch_det is on this clock and the register port is driven by the host interface.
`timescale 1ns/1ps
`include "tfd_cfg.svh"
module tfd_tone_driver
   import tfd_pkg::*;
#(
   parameter int MS_CYCLES = `TFD_MS_IN_NS / `TFD_CLK_PERIOD_NS,
   parameter int HALF_BASE = `TFD_CLK_HZ / (2 * `TFD_TONE_STEP_HZ)
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [13:0] touch_det,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic tone_out,
   output logic tone_active
);
   logic [7:0] tone_config;
   logic [6:0] tone_link_low;
   logic [6:0] tone_link_high;
   logic [7:0] next_config;
   logic [6:0] next_link_low;
   logic [6:0] next_link_high;
   logic [7:0] next_rdata;
   logic [13:0] touch_q;
   logic [13:0] link_all;
   logic [2:0] cfg_dur;
   logic start_touch;
   logic start_shot;
   logic start;
   logic shot_wr;
   tfd_state_type state;
   tfd_state_type next_state;
   logic [2:0] run_dur;
   logic [4:0] run_freq;
   logic [13:0] run_link;
   logic [2:0] next_run_dur;
   logic [4:0] next_run_freq;
   logic [13:0] next_run_link;
   logic [16:0] ms_cnt;
   logic [16:0] next_ms_cnt;
   logic [8:0] elapsed;
   logic [8:0] next_elapsed;
   logic [8:0] limit;
   logic ms_tick;
   logic done;
   logic restart_q;

   assign link_all = {tone_link_high, tone_link_low};
   assign cfg_dur = tone_config[`TFD_DUR_MSB:`TFD_DUR_LSB];
   assign shot_wr = reg_wr && reg_addr == `TFD_ADDR_TRIGGER;

   // Register file
   always_comb
   begin
      next_config = tone_config;
      next_link_low = tone_link_low;
      next_link_high = tone_link_high;
      next_rdata = reg_rdata;
      if (reg_wr)
      begin
         unique case (reg_addr)
            `TFD_ADDR_CONFIG: next_config = reg_wdata;
            `TFD_ADDR_LINK_LO: next_link_low = reg_wdata[`TFD_LINK_MSB:0];
            `TFD_ADDR_LINK_HI: next_link_high = reg_wdata[`TFD_LINK_MSB:0];
            default: next_config = tone_config;
         endcase
      end
      if (reg_rd)
      begin
         unique case (reg_addr)
            `TFD_ADDR_CONFIG: next_rdata = tone_config;
            `TFD_ADDR_LINK_LO: next_rdata = {1'b0, tone_link_low};
            `TFD_ADDR_LINK_HI: next_rdata = {1'b0, tone_link_high};
            default: next_rdata = `TFD_RESET_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tone_config <= `TFD_RESET_BYTE;
         tone_link_low <= 7'(`TFD_RESET_BYTE);
         tone_link_high <= 7'(`TFD_RESET_BYTE);
         reg_rdata <= `TFD_RESET_BYTE;
      end
      else
      begin
         tone_config <= next_config;
         tone_link_low <= next_link_low;
         tone_link_high <= next_link_high;
         reg_rdata <= next_rdata;
      end
   end

   assign start_touch = (|(touch_det & ~touch_q & link_all)) && cfg_dur != `TFD_DUR_OFF;
   assign start_shot = shot_wr && cfg_dur != `TFD_DUR_OFF && cfg_dur != `TFD_DUR_HOLD;
   assign start = start_touch || start_shot;
   assign ms_tick = ms_cnt == 17'(MS_CYCLES - 1);
   assign limit = `TFD_DUR_BASE_MS << (run_dur - 3'h1);
   assign done = (run_dur == `TFD_DUR_HOLD) ? !(|(touch_det & run_link)) : (ms_tick && elapsed == limit - 9'h001);

   always_comb
   begin
      next_state = state;
      next_run_dur = run_dur;
      next_run_freq = run_freq;
      next_run_link = run_link;
      next_ms_cnt = ms_tick ? 17'h00000 : ms_cnt + 17'h00001;
      next_elapsed = ms_tick ? elapsed + 9'h001 : elapsed;
      if (start)
      begin
         next_state = TFD_RUN;
         next_run_dur = cfg_dur;
         next_run_freq = tone_config[`TFD_FREQ_MSB:`TFD_FREQ_LSB];
         next_run_link = link_all;
         next_ms_cnt = 17'h00000;
         next_elapsed = 9'h000;
      end
      else
      begin
         unique case (state)
            TFD_IDLE:
            begin
               next_ms_cnt = 17'h00000;
               next_elapsed = 9'h000;
            end
            TFD_RUN:
            begin
               if (done)
               begin
                  next_state = TFD_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state <= TFD_IDLE;
         run_dur <= `TFD_DUR_OFF;
         run_freq <= `TFD_FREQ_DC;
         run_link <= 14'h0000;
         ms_cnt <= 17'h00000;
         elapsed <= 9'h000;
         touch_q <= 14'h0000;
         restart_q <= 1'b0;
      end
      else
      begin
         state <= next_state;
         run_dur <= next_run_dur;
         run_freq <= next_run_freq;
         run_link <= next_run_link;
         ms_cnt <= next_ms_cnt;
         elapsed <= next_elapsed;
         touch_q <= touch_det;
         restart_q <= start;
      end
   end

   assign tone_active = state == TFD_RUN;

   tfd_tone_gen #(.HALF_BASE(HALF_BASE)) u_tone
   (
      .clk(clk),
      .rst(rst),
      .run(tone_active),
      .restart(restart_q),
      .freq(run_freq),
      .tone(tone_out)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_link_touch_start: assert property (start_touch |=> state == TFD_RUN && restart_q)
      else $error("linked touch did not start");
   a_off_stays_idle: assert property (state == TFD_IDLE && cfg_dur == `TFD_DUR_OFF
      |=> state == TFD_IDLE) else $error("disabled duration started");
   a_fixed_end: assert property (state == TFD_RUN && run_dur != `TFD_DUR_HOLD && done && !start
      |=> state == TFD_IDLE ##1 !tone_out) else $error("fixed duration did not end");
   a_hold_on: assert property (state == TFD_RUN && run_dur == `TFD_DUR_HOLD
      && (|(touch_det & run_link)) |=> state == TFD_RUN) else $error("hold mode dropped early");
   a_hold_end: assert property (state == TFD_RUN && run_dur == `TFD_DUR_HOLD
      && !(|(touch_det & run_link)) && !start |=> state == TFD_IDLE)
      else $error("hold mode kept after release");
   a_dc_high: assert property (state == TFD_RUN && run_freq == `TFD_FREQ_DC |=> tone_out)
      else $error("DC output not high");
   a_settings_kept: assert property (state == TFD_RUN && !start
      |=> run_dur == $past(run_dur) && run_freq == $past(run_freq))
      else $error("settings changed mid activity");
   a_restart_fresh: assert property (state == TFD_RUN && start_touch
      |=> elapsed == 9'h000 && run_dur == $past(cfg_dur)) else $error("restart not fresh");
   a_shot_fires: assert property (start_shot |=> tone_active ##1 tone_out)
      else $error("one-shot did not fire");
   a_shot_ignored: assert property (shot_wr && !start_touch && state == TFD_IDLE
      && (cfg_dur == `TFD_DUR_OFF || cfg_dur == `TFD_DUR_HOLD) |=> state == TFD_IDLE)
      else $error("one-shot not ignored");
   a_trigger_zero: assert property (reg_rd && reg_addr == `TFD_ADDR_TRIGGER
      |=> reg_rdata == `TFD_RESET_BYTE) else $error("trigger reads nonzero");
   a_config_read: assert property (reg_rd && reg_addr == `TFD_ADDR_CONFIG
      |=> reg_rdata == $past(tone_config)) else $error("config readback wrong");

   c_shot: cover property (start_shot ##1 tone_active);
   c_restart: cover property (state == TFD_RUN && start_touch);
   c_hold: cover property (state == TFD_RUN && run_dur == `TFD_DUR_HOLD ##1 state == TFD_IDLE);
   c_dc: cover property (state == TFD_RUN && run_freq == `TFD_FREQ_DC);
endmodule : tfd_tone_driver

// >>> rtl/tfd_tone_gen.sv
// Tone wave generator: square wave at freq x step, or steady high for DC.
// Assumes run and restart come from the driver FSM on the same clock.
`timescale 1ns/1ps
`include "tfd_cfg.svh"
module tfd_tone_gen
   import tfd_pkg::*;
#(
   parameter int HALF_BASE = `TFD_CLK_HZ / (2 * `TFD_TONE_STEP_HZ)
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic restart,
   input wire logic [4:0] freq,
   output logic tone
);
   logic [17:0] acc;
   logic [17:0] next_acc;
   logic level;
   logic next_level;
   logic next_tone;
   logic [17:0] sum;

   always_comb
   begin
      sum = acc + 18'(freq);
      next_acc = acc;
      next_level = level;
      if (!run || restart)
      begin
         next_acc = 18'h00000;
         next_level = 1'b1;
      end
      else if (freq != `TFD_FREQ_DC)
      begin
         if (sum >= 18'(HALF_BASE))
         begin
            next_acc = sum - 18'(HALF_BASE);
            next_level = ~level;
         end
         else
         begin
            next_acc = sum;
         end
      end
      next_tone = run ? ((freq == `TFD_FREQ_DC) ? 1'b1 : next_level) : 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         acc <= 18'h00000;
         level <= 1'b1;
         tone <= 1'b0;
      end
      else
      begin
         acc <= next_acc;
         level <= next_level;
         tone <= next_tone;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_tone_toggle: assert property (run && !restart && freq != `TFD_FREQ_DC && sum >= 18'(HALF_BASE)
      |=> level != $past(level)) else $error("tone half period missed");
   a_idle_low: assert property (!run |=> !tone) else $error("tone active while idle");
endmodule : tfd_tone_gen
